// ---- design/sar_adc_sequencer_serial_out.sv ----
// Purpose: Track/hold sequencing, coding and serial output of a SAR converter
// Assumes: Comparator decision arrives on comparator_i, synchronous to core_clk_i
// Notes:   External shift clock is its own domain; its falling edges cross as a synchronised toggle, the word stays in the core domain
`timescale 1ns/10ps
`default_nettype none

module sar_adc_sequencer_serial_out
  import sar_seq_pkg::*;
#(
  parameter int unsigned CAL_FAST   = CAL_FAST_CYCLES,
  parameter int unsigned CAL_LOWPWR = CAL_LOWPWR_CYCLES
) (
  input  wire logic core_clk_i,
  input  wire logic reset_n_i,
  input  wire logic hold_n_i,
  input  wire logic coarse_fine_select_i,
  input  wire config_s cfg_i,
  input  wire logic channel_select_i,
  input  wire logic comparator_i,
  input  wire logic ext_shift_clk_i,
  output logic      serial_result_out_o,
  output logic      shift_clock_o,
  output logic      shift_clock_oe_n_o,
  output logic      data_frame_strobe_o,
  output logic      channel_select_o,
  output logic      channel_select_oe_n_o,
  output status_s   status_o,
  output logic      sample_hold_o,
  output logic      sar_trial_o,
  output logic [3:0] sar_bit_o
);

  // ==========================================================
  // Input synchronisers
  logic [1:0] hold_sync_r;
  logic [4:0] cfg_meta_r;
  config_s    cfg_r;
  logic [1:0] crs_sync_r;
  logic [1:0] cmp_sync_r;
  logic [1:0] chsel_sync_r;
  logic       hold_fall_r;
  logic       hold_prev_r;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_meta_r   <= '0;
      cfg_r        <= '0;
      crs_sync_r   <= '0;
      cmp_sync_r   <= '0;
      chsel_sync_r <= '0;
    end else begin
      cfg_meta_r   <= cfg_i;
      cfg_r        <= cfg_meta_r;
      crs_sync_r   <= {crs_sync_r[0], coarse_fine_select_i};
      cmp_sync_r   <= {cmp_sync_r[0], comparator_i};
      chsel_sync_r <= {chsel_sync_r[0], channel_select_i};
    end
  end

  always_ff @(negedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hold_sync_r <= 2'b11;
    end else begin
      hold_sync_r <= {hold_sync_r[0], hold_n_i};
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hold_prev_r <= 1'b1;
      hold_fall_r <= 1'b0;
    end else begin
      hold_prev_r <= hold_sync_r[1];
      hold_fall_r <= hold_prev_r & ~hold_sync_r[1];
    end
  end

  out_mode_e mode;
  assign mode = out_mode_e'({cfg_r.shift_clock_direction_select, cfg_r.output_timing_select});
  logic self_clk;
  assign self_clk = ~cfg_r.shift_clock_direction_select;

  // ==========================================================
  // Sequencer
  seq_state_e state_r;
  logic [23:0] cnt_r;
  logic [6:0]  fr_cnt_r;
  logic [3:0]  bit_r;
  logic [15:0] sar_r;
  logic        start;
  logic        done;
  logic        conv_edge;

  assign start = (mode == FREE_RUNNING_LOOP_MODE) ? (fr_cnt_r == 7'(FREERUN_PERIOD - 1)) : hold_fall_r;
  assign done  = (state_r == ST_CONVERT) && (cnt_r == 24'(CONV_CYCLES - 1));
  assign conv_edge = (state_r == ST_CONVERT) && (cnt_r >= 24'(BIT_START)) &&
                     (cnt_r[1:0] == 2'(BIT_START)) && (cnt_r < 24'(BIT_START + SELF_CLK_DIV * BITS));

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= ST_CAL;
      cnt_r   <= '0;
    end else begin
      case (state_r)
        ST_CAL: begin
          cnt_r <= cnt_r + 24'd1;
          if (cnt_r == 24'((cfg_r.low_power_grade ? CAL_LOWPWR : CAL_FAST) - 1)) begin
            state_r <= ST_TRACK;
            cnt_r   <= '0;
          end
        end
        ST_TRACK: begin
          if (cnt_r != 24'(COARSE_CYCLES)) begin
            cnt_r <= cnt_r + 24'd1;
          end
          if (start) begin
            state_r <= ST_CONVERT;
            cnt_r   <= '0;
          end
        end
        ST_CONVERT: begin
          cnt_r <= cnt_r + 24'd1;
          if (done) begin
            state_r <= ST_TRACK;
            cnt_r   <= '0;
          end
        end
        default: begin
          state_r <= ST_CAL;
          cnt_r   <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fr_cnt_r <= '0;
    end else if (state_r == ST_CAL || mode != FREE_RUNNING_LOOP_MODE ||
                 fr_cnt_r == 7'(FREERUN_PERIOD - 1)) begin
      fr_cnt_r <= '0;
    end else begin
      fr_cnt_r <= fr_cnt_r + 7'd1;
    end
  end

  // Successive approximation register, one bit per four master cycles
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sar_r <= RESULT_RST;
      bit_r <= 4'hf;
    end else if (start && state_r == ST_TRACK) begin
      sar_r <= RESULT_RST;
      bit_r <= 4'hf;
    end else if (conv_edge) begin
      sar_r[bit_r] <= cmp_sync_r[1];
      bit_r        <= bit_r - 4'd1;
    end
  end

  // range offset lives in the analog array
  logic [15:0] coded;
  assign coded = cfg_r.code_select ? (sar_r ^ SIGN_FLIP) : sar_r;

  // ==========================================================
  // Result hand-off to the external shift clock domain
  logic [15:0] result_r;
  logic        pend_r;
  logic [15:0] xshift_r;
  logic        fall_tgl_r;
  logic [2:0]  fall_sync_r;
  logic        xfall;
  logic        burst_load;
  logic        pipe_load;
  logic        buf_clear;

  assign burst_load = done && (mode == REGISTERED_BURST_MODE);
  assign buf_clear  = hold_fall_r && (state_r == ST_TRACK);
  assign pipe_load  = buf_clear && (mode == PIPELINED_TRANSFER_MODE) && pend_r;
  assign xfall      = fall_sync_r[2] ^ fall_sync_r[1];

  // result held and released by mode
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      result_r <= RESULT_RST;
      pend_r   <= 1'b0;
    end else begin
      if (done) begin
        result_r <= coded;
      end
      if (done && !burst_load) begin
        pend_r <= 1'b1;
      end else if (pipe_load) begin
        pend_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // External shift clock domain
  // Each falling edge flips a toggle; the word stays in the core domain so the MSB stands before the first edge
  always_ff @(negedge ext_shift_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fall_tgl_r <= 1'b0;
    end else begin
      fall_tgl_r <= ~fall_tgl_r;
    end
  end

  // MSB first, one bit per falling edge, ones after sixteen
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fall_sync_r <= '0;
      xshift_r    <= SHIFT_FILL;
    end else begin
      fall_sync_r <= {fall_sync_r[1:0], fall_tgl_r};
      if (burst_load) begin
        xshift_r <= coded;
      end else if (pipe_load) begin
        xshift_r <= result_r;
      end else if (buf_clear) begin
        xshift_r <= SHIFT_FILL;
      end else if (xfall) begin
        xshift_r <= {xshift_r[14:0], 1'b1};
      end
    end
  end

  // ==========================================================
  // Self-clocked shift clock, data and frame strobe
  logic       sclk_r;
  logic       sdat_r;
  logic       frame_r;
  logic [4:0] pulses_r;
  logic [1:0] tail_r;
  logic       sc_active;

  assign sc_active = (state_r == ST_CONVERT) && (cnt_r >= 24'(BIT_START)) &&
                     (cnt_r < 24'(BIT_START + SELF_CLK_DIV * BITS));

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sclk_r   <= 1'b1;
      sdat_r   <= 1'b1;
      pulses_r <= '0;
    end else if (self_clk && sc_active) begin
      sclk_r <= ~cnt_r[1];
      if (cnt_r[1:0] == 2'(BIT_START + 1)) begin
        sdat_r   <= cmp_sync_r[1] ^ (cfg_r.code_select & (bit_r == 4'd14));
        pulses_r <= pulses_r + 5'd1;
      end
    end else begin
      sclk_r <= 1'b1;
      if (state_r == ST_TRACK) begin
        pulses_r <= '0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frame_r <= 1'b1;
      tail_r  <= '0;
    end else if (!self_clk) begin
      frame_r <= 1'b1;
      tail_r  <= '0;
    end else if (sc_active && cnt_r == 24'(BIT_START) && pulses_r == 5'd0) begin
      frame_r <= 1'b0;
    end else if (!frame_r && pulses_r == 5'(BITS) && sclk_r) begin
      tail_r <= tail_r + 2'd1;
      if (tail_r == 2'(STROBE_TAIL - 1)) begin
        frame_r <= 1'b1;
        tail_r  <= '0;
      end
    end
  end

  logic chan_r;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      chan_r <= 1'b1;
    end else if (mode == FREE_RUNNING_LOOP_MODE) begin
      if (start && state_r == ST_TRACK) begin
        chan_r <= ~chan_r;
      end
    end else begin
      chan_r <= chsel_sync_r[1];
    end
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      serial_result_out_o   <= 1'b1;
      shift_clock_o         <= 1'b1;
      shift_clock_oe_n_o    <= 1'b1;
      data_frame_strobe_o   <= 1'b1;
      channel_select_o      <= 1'b1;
      channel_select_oe_n_o <= 1'b1;
      status_o              <= '0;
      sample_hold_o         <= 1'b0;
      sar_trial_o           <= 1'b0;
      sar_bit_o             <= 4'hf;
    end else begin
      serial_result_out_o   <= self_clk ? sdat_r : xshift_r[15];
      shift_clock_o         <= sclk_r;
      shift_clock_oe_n_o    <= ~self_clk;
      data_frame_strobe_o   <= frame_r;
      channel_select_o      <= chan_r;
      channel_select_oe_n_o <= (mode != FREE_RUNNING_LOOP_MODE);
      status_o.calibration_done_flag <= (state_r != ST_CAL);
      status_o.track_indicator_one   <= (state_r == ST_TRACK) && chan_r;
      status_o.track_indicator_two   <= (state_r == ST_TRACK) && !chan_r;
      status_o.coarse_charge <= (state_r == ST_TRACK) &&
                                (crs_sync_r[1] || cnt_r < 24'(COARSE_CYCLES));
      sample_hold_o <= (state_r == ST_CONVERT) || (start && state_r == ST_TRACK);
      sar_trial_o   <= conv_edge;
      sar_bit_o     <= bit_r;
    end
  end

endmodule

`default_nettype wire

// ---- design/sar_seq_pkg.sv ----
// Purpose: Shared constants and types for the converter sequencer
// Assumes: Master clock of 100 MHz on core_clk_i
// Notes:   Calibration lengths are defaults of top-level parameters
package sar_seq_pkg;

  // ==========================================================
  // Timing constants
  localparam int unsigned COARSE_CYCLES      = 6;
  localparam int unsigned CONV_CYCLES        = 66;
  localparam int unsigned FREERUN_PERIOD     = 80;
  localparam int unsigned BITS               = 16;
  localparam int unsigned STROBE_TAIL        = 2;
  localparam int unsigned CAL_FAST_CYCLES    = 11528160;
  localparam int unsigned CAL_LOWPWR_CYCLES  = 2882040;
  localparam int unsigned SELF_CLK_DIV       = 4;
  localparam int unsigned BIT_START          = 2;

  // ==========================================================
  // Reset values and code mask
  localparam logic [15:0] RESULT_RST        = 16'h0000;
  localparam logic [15:0] SHIFT_FILL        = 16'hffff;
  localparam logic [15:0] SIGN_FLIP         = 16'h8000;

  // ==========================================================
  // Modes and states
  typedef enum logic [1:0] {
    FREE_RUNNING_LOOP_MODE,
    SELF_CLOCKED_MODE,
    REGISTERED_BURST_MODE,
    PIPELINED_TRANSFER_MODE
  } out_mode_e;

  typedef enum logic [1:0] {
    ST_CAL,
    ST_TRACK,
    ST_CONVERT
  } seq_state_e;

  typedef struct packed {
    logic range_polarity_select;
    logic code_select;
    logic shift_clock_direction_select;
    logic output_timing_select;
    logic low_power_grade;
  } config_s;

  typedef struct packed {
    logic track_indicator_one;
    logic track_indicator_two;
    logic calibration_done_flag;
    logic coarse_charge;
  } status_s;

endpackage

// ---- sim/sar_seq_checker.sv ----
// Purpose: Port checks of the converter sequencer
// Assumes: One clock domain, bound to the top
// Notes:   Calibration length follows bound parameters
`timescale 1ns/10ps
`default_nettype none
module sar_seq_checker
  import sar_seq_pkg::*;
#(
  parameter int unsigned CAL_FAST   = 50,
  parameter int unsigned CAL_LOWPWR = 50
) (
  input wire logic    core_clk_i,
  input wire logic    reset_n_i,
  input wire logic    coarse_fine_select_i,
  input wire config_s cfg_i,
  input wire logic    shift_clock_o,
  input wire logic    shift_clock_oe_n_o,
  input wire logic    data_frame_strobe_o,
  input wire logic    channel_select_o,
  input wire logic    channel_select_oe_n_o,
  input wire status_s status_o,
  input wire logic    sample_hold_o
);
  // ======
  // Helpers
  logic [31:0] cal_n_r;
  logic [4:0]  n_fall_r;
  wire         fr = !cfg_i.shift_clock_direction_select && !cfg_i.output_timing_select;
  wire         sc = !shift_clock_oe_n_o;
  wire [31:0]  cal_exp = cfg_i.low_power_grade ? CAL_LOWPWR : CAL_FAST;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) cal_n_r <= '0;
    else if (!status_o.calibration_done_flag) cal_n_r <= cal_n_r + 32'h1;
  end
  // Counts shift clock falls within a frame
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) n_fall_r <= '0;
    else if ($fell(data_frame_strobe_o)) n_fall_r <= 5'h1;
    else if ($fell(shift_clock_o)) n_fall_r <= n_fall_r + 5'h1;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // ======
  // Assertions
  AST_CAL_LEN: assert property ($rose(status_o.calibration_done_flag) |->
    cal_n_r >= cal_exp && cal_n_r <= cal_exp + 32'h4) else $error("calibration length wrong");
  AST_HOLD_IN_CAL: assert property (!status_o.calibration_done_flag |-> !sample_hold_o)
    else $error("conversion during calibration");
  AST_COARSE_SIX: assert property ($rose(status_o.coarse_charge) && !coarse_fine_select_i
    && !$past(coarse_fine_select_i, 3) |-> status_o.coarse_charge [*6] ##1 !status_o.coarse_charge)
    else $error("coarse charge not six cycles");
  AST_SCLK_IDLE: assert property (sc && !sample_hold_o && !$past(sample_hold_o, 2) |-> shift_clock_o)
    else $error("shift clock low between conversions");
  AST_SCLK_DIR: assert property ($stable(cfg_i) [*4] && status_o.calibration_done_flag |->
    shift_clock_oe_n_o == cfg_i.shift_clock_direction_select) else $error("shift clock direction wrong");
  AST_CH_DIR: assert property ($stable(cfg_i) [*4] && status_o.calibration_done_flag |->
    channel_select_oe_n_o == !fr)
    else $error("channel pin direction wrong");
  AST_FR_PERIOD: assert property (fr && $rose(sample_hold_o) |-> ##80 $rose(sample_hold_o))
    else $error("free run period wrong");
  AST_CH_ALT: assert property (fr && $rose(sample_hold_o) |->
    ##82 channel_select_o != $past(channel_select_o, 40)) else $error("channel not alternating");
  AST_STROBE_FALL: assert property ($fell(data_frame_strobe_o) |-> $fell(shift_clock_o))
    else $error("strobe fell without shift clock");
  AST_STROBE_TAIL: assert property (sc && $rose(shift_clock_o) && n_fall_r == 5'h10 |->
    !data_frame_strobe_o ##2 data_frame_strobe_o) else $error("strobe tail wrong");
  AST_SIXTEEN: assert property (sc && $rose(data_frame_strobe_o) |-> n_fall_r == 5'h10)
    else $error("pulse count not sixteen");
  cover property (fr && $rose(sample_hold_o));
  cover property (sc && $rose(data_frame_strobe_o));
  cover property ($rose(status_o.calibration_done_flag));
endmodule
bind sar_adc_sequencer_serial_out sar_seq_checker #(.CAL_FAST(CAL_FAST), .CAL_LOWPWR(CAL_LOWPWR)) u_chk (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .coarse_fine_select_i(coarse_fine_select_i),
  .cfg_i(cfg_i), .shift_clock_o(shift_clock_o), .shift_clock_oe_n_o(shift_clock_oe_n_o),
  .data_frame_strobe_o(data_frame_strobe_o), .channel_select_o(channel_select_o),
  .channel_select_oe_n_o(channel_select_oe_n_o), .status_o(status_o), .sample_hold_o(sample_hold_o));
`default_nettype wire

// ---- sim/host_shift_rx.sv ----
// Purpose: Host shift register on the serial port
// Assumes: Bench resolves the shift clock pin
// Notes:   Host clock built from a free 12 ns tick
`timescale 1ns/10ps
`default_nettype none
module host_shift_rx (
  input  wire logic       sclk_pin_i,
  input  wire logic       serial_result_out_i,
  output var logic        host_sclk_o,
  output var logic [31:0] rx_o,
  output var logic [7:0]  nbits_o
);
  logic tick;
  initial begin
    tick = 1'b0;
    host_sclk_o = 1'b0;
    #3;
    forever #6 tick = ~tick;
  end
  always @(posedge sclk_pin_i) begin
    rx_o <= {rx_o[30:0], serial_result_out_i};
    nbits_o <= nbits_o + 8'h01;
  end
  task automatic clear();
    rx_o = '0;
    nbits_o = '0;
  endtask
  task automatic read_bits(input int n);
    repeat (n) begin
      repeat (9) @(posedge tick);
      host_sclk_o = 1'b1;
      repeat (9) @(posedge tick);
      host_sclk_o = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ---- sim/test_sar_adc_sequencer_serial_out.sv ----
// Purpose: Self-checking bench of the converter sequencer
// Assumes: Host model reads the serial port
// Notes:   Calibration shortened to CAL cycles
`timescale 1ns/10ps
`default_nettype none
module test_sar_adc_sequencer_serial_out;
  import sar_seq_pkg::*;
  localparam int CAL = 50;
  logic        core_clk, reset_n, hold_n, crs, ch_host, cmp, serial_result_out, sclk, sclk_oe_n;
  logic        strobe, ch, ch_oe_n, sh, host_sclk;
  logic [3:0]  sbit;
  logic [15:0] cmp_word;
  logic [31:0] rx;
  logic [7:0]  nbits;
  config_s     cfg;
  status_s     st;
  wire         sclk_pin;
  wire         ch_pin;
  int          mismatches;
  int          n_checks;
  assign sclk_pin = sclk_oe_n ? host_sclk : sclk;
  assign ch_pin = ch_oe_n ? ch_host : ch;
  sar_adc_sequencer_serial_out #(.CAL_FAST(CAL), .CAL_LOWPWR(CAL)) DUT (
    .core_clk_i(core_clk), .reset_n_i(reset_n), .hold_n_i(hold_n), .coarse_fine_select_i(crs), .cfg_i(cfg),
    .channel_select_i(ch_pin), .comparator_i(cmp), .ext_shift_clk_i(sclk_pin), .serial_result_out_o(serial_result_out),
    .shift_clock_o(sclk), .shift_clock_oe_n_o(sclk_oe_n), .data_frame_strobe_o(strobe), .channel_select_o(ch),
    .channel_select_oe_n_o(ch_oe_n), .status_o(st), .sample_hold_o(sh), .sar_trial_o(), .sar_bit_o(sbit));
  host_shift_rx u_host (.sclk_pin_i(sclk_pin), .serial_result_out_i(serial_result_out), .host_sclk_o(host_sclk), .rx_o(rx),
    .nbits_o(nbits));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Comparator answers the bit under trial at once
  assign cmp = cmp_word[sbit];
  // ======
  // Helpers
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wait_sh(input logic lvl);
    int i;
    for (i = 0; i < 2000 && sh !== lvl; i++) @(negedge core_clk);
    if (sh !== lvl) begin
      chk(sh, lvl);
      end_of_test();
    end
  endtask
  task automatic rd(input int n);
    u_host.read_bits(n);
    @(posedge core_clk);
  endtask
  task automatic mode(input logic d, input logic t, input logic c);
    cfg.shift_clock_direction_select <= d;
    cfg.output_timing_select <= t;
    cfg.code_select <= c;
    cfg.range_polarity_select <= c;
    cyc(6);
  endtask
  task automatic start(input logic [15:0] w);
    cmp_word <= w;
    hold_n <= 1'b0;
    cyc(2);
    hold_n <= 1'b1;
    wait_sh(1'b1);
  endtask
  // hold_n low two master cycles; one conversion, then long track of 190 master cycles
  task automatic conv(input logic [15:0] w);
    start(w);
    wait_sh(1'b0);
    cyc(190);
  endtask
  // ======
  // Scenarios
  task automatic t_reset();
    int i;
    reset_n <= 1'b0;
    cyc(12);
    reset_n <= 1'b1;
    cyc(10);
    hold_n <= 1'b0;
    for (i = 10; i < 300 && st.calibration_done_flag !== 1'b1; i++) @(negedge core_clk);
    chk(32'(i >= CAL && i <= CAL + 5), 32'h1);
    chk(sh, 1'b0);
    @(posedge core_clk);
    hold_n <= 1'b1;
    cyc(4);
  endtask
  task automatic t_self();
    logic [16:0] tab [4] = '{17'h0ffff, 17'h1ffff, 17'h10000, 17'h0a5c3};
    for (int k = 0; k < 4; k++) begin
      mode(1'b0, 1'b1, tab[k][16]);
      ch_host <= k[0];
      u_host.clear();
      conv(tab[k][15:0]);
      chk(rx[15:0], tab[k][16] ? tab[k][15:0] ^ SIGN_FLIP : tab[k][15:0]);
      chk(nbits, 8'h10);
    end
  endtask
  task automatic t_coarse();
    for (int k = 0; k < 2; k++) begin
      crs <= (k == 0);
      cyc(6);
      @(negedge core_clk);
      chk(st.coarse_charge, (k == 0));
      @(posedge core_clk);
    end
  endtask
  task automatic t_burst();
    mode(1'b1, 1'b0, 1'b0);
    u_host.clear();
    conv(16'h1234);
    rd(20);
    chk(rx[19:0], {16'h1234, 4'hf});
    u_host.clear();
    start(16'h4321);
    rd(2);
    chk(rx[1:0], 2'b11);
    wait_sh(1'b0);
    cyc(190);
  endtask
  task automatic t_pipe();
    mode(1'b1, 1'b1, 1'b0);
    conv(16'hc3a5);
    u_host.clear();
    start(16'h5a0f);
    rd(4);
    chk(rx[3:0], 4'hc);
    wait_sh(1'b0);
    cyc(190);
    u_host.clear();
    start(16'h0001);
    rd(16);
    chk(rx[15:0], 16'h5a0f);
    wait_sh(1'b0);
    cyc(190);
  endtask
  task automatic t_free();
    logic c0;
    mode(1'b0, 1'b0, 1'b0);
    hold_n <= 1'b0;
    wait_sh(1'b1);
    wait_sh(1'b0);
    cyc(4);
    u_host.clear();
    c0 = ch_pin;
    wait_sh(1'b1);
    wait_sh(1'b0);
    cyc(4);
    chk(rx[15:0], cmp_word);
    chk(ch_pin, !c0);
  endtask
  initial begin
    reset_n = 1'b0;
    hold_n = 1'b1;
    crs = 1'b0;
    ch_host = 1'b0;
    cmp_word = 16'h0000;
    cfg = '0;
    mismatches = 0;
    n_checks = 0;
    t_reset();
    t_self();
    t_coarse();
    t_burst();
    t_reset();
    t_pipe();
    t_free();
    end_of_test();
  end
endmodule
`default_nettype wire
